// [design/cmc_mode_control.sv]
// Mode-control registers of the CAN controller with an AXI4-Lite register slave.
// How it works
// [RQ1] Bit 7 enables the CAN module when 1, disables when 0.
// [RQ2] Enable bit is write-once in normal mode; freely rewritable in special mode.
// [RQ3] Register always readable; writes land only while init request and acknowledge are set.
// [RQ4] Bit 6 picks the module clock: oscillator at 0, bus clock at 1.
// [RQ5] Loopback feeds transmit bits to the receiver; receive pin ignored, transmit pin recessive.
// [RQ6] Loopback transmits normally and ignores the acknowledge slot sample.
// [RQ7] Loopback still raises transmit and receive events as in normal operation.
// [RQ8] Listen-only receives matching frames but never drives acknowledge or error frames.
// [RQ9] Listen-only freezes both error counters.
// [RQ10] Listen-only forbids transmitting frames.
// [RQ11] Wake enabled with filter bit 0: any dominant level wakes the block.
// [RQ12] Wake enabled with filter bit 1: only dominant pulses of the filter time wake.
// [RQ13] Read-only bit 1 acknowledges sleep; sleep active when request and acknowledge set.
// [RQ14] With wake enabled, bus activity in sleep clears the sleep acknowledge.
// [RQ15] Read-only bit 0 acknowledges init; init active when request and acknowledge set.
// [RQ16] Control, timing and acceptance registers are write-protected outside initialization.
// [RQ17] After init exit, resync on 11 recessive bits, or 128 such runs if bus-off.
// [RQ18] Sleep is granted only with no reception running and no transmit pending.
// [RQ19] Clearing the init request before its acknowledge is ignored.
// [RQ20] Bit 3 reads zero and ignores writes.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module cmc_mode_control (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register bus
    input wire cmc_pkg::cmc_axil_req_t axilReq,
    output cmc_pkg::cmc_axil_rsp_t axilRsp,
    // System mode
    input wire logic specialMode,
    // CAN pins
    input wire logic busReceivePin,
    output logic busTransmitPin,
    // Frame engine
    input wire cmc_pkg::cmc_engine_in_t engIn,
    output cmc_pkg::cmc_engine_out_t engOut
);

    // Bus channels, registers and pin stages share one record, so one clocked
    // process owns every flop of the block outside the wake filter.
    typedef struct packed {
        cmc_pkg::cmc_axil_rsp_t rsp;
        logic awHeld;
        logic wHeld;
        logic [5:0] wIdx;
        logic [7:0] wData;
        logic wLane0;
        logic initReq;
        logic initAck;
        logic sleepReq;
        logic sleepAck;
        logic wakeEnable;
        logic enableLocked;
        logic [7:0] ctl1;
        logic [cmc_pkg::ACC_COUNT-1:0][7:0] accept;
        logic [7:0] tec;
        logic [7:0] rec;
        logic rxSync1;
        logic rxSync2;
        logic txPin;
        logic resyncing;
        logic [3:0] recBitCnt;
        logic [6:0] seqCnt;
        cmc_pkg::cmc_engine_out_t eng;
    } cmc_state_t;

    cmc_state_t st_ff;
    cmc_state_t nxt_st;
    logic wakePulse;
    logic initActive;
    logic sleepActive;
    logic [7:0] ctl1Read;

    // A mode counts only while its request and its acknowledge are both set.
    assign initActive = st_ff.initReq & st_ff.initAck; // [RQ15]
    assign sleepActive = st_ff.sleepReq & st_ff.sleepAck; // [RQ13]
    assign ctl1Read = {st_ff.ctl1[7:4], 1'b0, st_ff.ctl1[cmc_pkg::CTL1_WAKEFLT],
                       st_ff.sleepAck, st_ff.initAck}; // [RQ20]

    // The filter only runs while sleep is active and wake-up is enabled.
    cmc_wake_filter u_wake (
        .clk(clk),
        .srst(srst),
        .armed(sleepActive & st_ff.wakeEnable),
        .filterOn(st_ff.ctl1[cmc_pkg::CTL1_WAKEFLT]),
        .rxLevel(st_ff.rxSync2),
        .wakePulse(wakePulse)
    );

    // Status bits come from engine inputs on this clock, so they need no synchronizer;
    // they are still registered on their way into the read data.
    function automatic logic [31:0] readReg(input logic [5:0] idx, input cmc_state_t s,
                                            input logic [7:0] c1);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx >= cmc_pkg::IDX_ACC_BASE && idx <= cmc_pkg::IDX_ACC_LAST) begin
            v[7:0] = s.accept[4'(idx - cmc_pkg::IDX_ACC_BASE)];
        end else begin
            case (idx)
                cmc_pkg::IDX_CTL0: v[2:0] = {s.wakeEnable, s.sleepReq, s.initReq};
                cmc_pkg::IDX_CTL1: v[7:0] = c1; // [RQ3]
                cmc_pkg::IDX_BTR0: v[7:0] = s.eng.bitTiming0;
                cmc_pkg::IDX_BTR1: v[7:0] = s.eng.bitTiming1;
                cmc_pkg::IDX_IDAC: v[7:0] = s.eng.acceptCtl;
                cmc_pkg::IDX_ERRCNT: v[15:0] = {s.rec, s.tec};
                cmc_pkg::IDX_STATUS: v[3:0] = {s.eng.busSynced, engIn.busOff,
                                               engIn.txPending, engIn.rxBusy};
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // Unmapped indices answer with an error response and read as zero.
    function automatic logic isMapped(input logic [5:0] idx);
        return (idx <= cmc_pkg::IDX_STATUS) ||
               (idx >= cmc_pkg::IDX_ACC_BASE && idx <= cmc_pkg::IDX_ACC_LAST);
    endfunction

    always_comb begin
        nxt_st = st_ff;

        // Pin synchronizer; only the second stage is read by logic.
        nxt_st.rxSync1 = busReceivePin;
        nxt_st.rxSync2 = st_ff.rxSync1;

        // Write address and data channels, taken in either order.
        if (axilReq.awvalid && st_ff.rsp.awready) begin
            nxt_st.awHeld = 1'b1;
            nxt_st.wIdx = axilReq.awaddr[7:2];
        end
        if (axilReq.wvalid && st_ff.rsp.wready) begin
            nxt_st.wHeld = 1'b1;
            nxt_st.wData = axilReq.wdata[7:0];
            nxt_st.wLane0 = axilReq.wstrb[0];
        end
        if (st_ff.rsp.bvalid && axilReq.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end

        // Sleep handshake; the hardware set wins over a software clear.
        if (st_ff.sleepReq && !st_ff.sleepAck && !initActive &&
            !engIn.rxBusy && !engIn.txPending) begin
            nxt_st.sleepAck = 1'b1; // [RQ18]
        end
        // Dropping the request returns the block to running at once.
        if (!st_ff.sleepReq) begin
            nxt_st.sleepAck = 1'b0;
        end

        // A write lands one cycle after both halves are held, together with its response.
        // Only byte lane 0 carries register bits; without it the write is answered and dropped.
        if (st_ff.awHeld && st_ff.wHeld && !st_ff.rsp.bvalid) begin
            nxt_st.awHeld = 1'b0;
            nxt_st.wHeld = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = isMapped(st_ff.wIdx) ? cmc_pkg::RESP_OKAY
                                                    : cmc_pkg::RESP_SLVERR;
            if (st_ff.wLane0) begin
                // The request bits stay writable outside initialization, or software
                // could never leave it.
                if (st_ff.wIdx == cmc_pkg::IDX_CTL0) begin
                    nxt_st.wakeEnable = st_ff.wData[cmc_pkg::CTL0_WAKEEN];
                    if (st_ff.wData[cmc_pkg::CTL0_INITREQ] || st_ff.initAck) begin
                        nxt_st.initReq = st_ff.wData[cmc_pkg::CTL0_INITREQ]; // [RQ19]
                    end
                    if (st_ff.wData[cmc_pkg::CTL0_SLPREQ] || st_ff.sleepAck) begin
                        nxt_st.sleepReq = st_ff.wData[cmc_pkg::CTL0_SLPREQ];
                    end
                end else if (initActive) begin // [RQ3] [RQ16]
                    // Protected registers drop a late write silently but still answer OKAY.
                    if (st_ff.wIdx >= cmc_pkg::IDX_ACC_BASE &&
                        st_ff.wIdx <= cmc_pkg::IDX_ACC_LAST) begin
                        nxt_st.accept[4'(st_ff.wIdx - cmc_pkg::IDX_ACC_BASE)] = st_ff.wData;
                    end
                    case (st_ff.wIdx)
                        cmc_pkg::IDX_CTL1: begin
                            nxt_st.ctl1[6:4] = st_ff.wData[6:4];
                            nxt_st.ctl1[cmc_pkg::CTL1_WAKEFLT] =
                                st_ff.wData[cmc_pkg::CTL1_WAKEFLT];
                            // Locking the enable after its first write keeps stray code
                            // from switching the controller off later.
                            if (specialMode || !st_ff.enableLocked) begin
                                nxt_st.ctl1[cmc_pkg::CTL1_ENABLE] =
                                    st_ff.wData[cmc_pkg::CTL1_ENABLE]; // [RQ2]
                                nxt_st.enableLocked = !specialMode; // [RQ2]
                            end
                        end
                        cmc_pkg::IDX_BTR0: nxt_st.eng.bitTiming0 = st_ff.wData;
                        cmc_pkg::IDX_BTR1: nxt_st.eng.bitTiming1 = st_ff.wData;
                        cmc_pkg::IDX_IDAC: nxt_st.eng.acceptCtl = st_ff.wData;
                        default: nxt_st.wIdx = st_ff.wIdx;
                    endcase
                end
            end
        end
        // Address and data stay blocked until the response has been taken.
        nxt_st.rsp.awready = !nxt_st.awHeld && !nxt_st.rsp.bvalid;
        nxt_st.rsp.wready = !nxt_st.wHeld && !nxt_st.rsp.bvalid;

        // Read channel: one access at a time, answered on the next cycle.
        if (st_ff.rsp.rvalid && axilReq.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        if (axilReq.arvalid && st_ff.rsp.arready) begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata = readReg(axilReq.araddr[7:2], st_ff, ctl1Read); // [RQ3]
            nxt_st.rsp.rresp = isMapped(axilReq.araddr[7:2]) ? cmc_pkg::RESP_OKAY
                                                             : cmc_pkg::RESP_SLVERR;
        end
        nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

        // Bus activity in sleep ends sleep; the block drops its own request too.
        if (wakePulse) begin
            nxt_st.sleepAck = 1'b0; // [RQ14]
            nxt_st.sleepReq = 1'b0;
        end

        // The init acknowledge trails its request by one cycle; entering
        // initialization also ends any sleep.
        nxt_st.initAck = st_ff.initReq; // [RQ15]
        if (st_ff.initReq) begin
            nxt_st.sleepAck = 1'b0;
        end

        // Leaving initialization starts a fresh count; a dominant bit restarts the run,
        // and bus-off recovery needs every run before the block is back on the bus.
        if (st_ff.initReq) begin
            nxt_st.eng.busSynced = 1'b0;
            nxt_st.resyncing = 1'b0;
        end else if (st_ff.initAck) begin
            nxt_st.resyncing = 1'b1; // [RQ17]
            nxt_st.recBitCnt = 4'h0;
            nxt_st.seqCnt = 7'h00;
        end else if (st_ff.resyncing && engIn.bitTick) begin
            if (!st_ff.eng.rxBit) begin
                nxt_st.recBitCnt = 4'h0;
            end else if (st_ff.recBitCnt == cmc_pkg::RESYNC_BITS - 4'h1) begin
                nxt_st.recBitCnt = 4'h0;
                if (!engIn.busOff || st_ff.seqCnt == cmc_pkg::BUSOFF_SEQ_LAST) begin
                    nxt_st.resyncing = 1'b0; // [RQ17]
                    nxt_st.eng.busSynced = 1'b1;
                end else begin
                    nxt_st.seqCnt = st_ff.seqCnt + 7'h01; // [RQ17]
                end
            end else begin
                nxt_st.recBitCnt = st_ff.recBitCnt + 4'h1;
            end
        end

        // Error counters hold still while only listening.
        if (engIn.errLoad && !st_ff.ctl1[cmc_pkg::CTL1_LISTEN]) begin
            nxt_st.tec = engIn.tecIn; // [RQ9]
            nxt_st.rec = engIn.recIn;
        end

        // Pin and engine steering.
        nxt_st.eng.moduleEnable = st_ff.ctl1[cmc_pkg::CTL1_ENABLE]; // [RQ1]
        nxt_st.eng.clockSourceSelect = st_ff.ctl1[cmc_pkg::CTL1_CLOCK_SOURCE_SELECT]; // [RQ4]
        nxt_st.eng.rxBit = st_ff.ctl1[cmc_pkg::CTL1_LOOP] ? engIn.txBit
                                                          : st_ff.rxSync2; // [RQ5]
        nxt_st.eng.ackIgnore = st_ff.ctl1[cmc_pkg::CTL1_LOOP]; // [RQ6]
        nxt_st.eng.txAllowed = st_ff.ctl1[cmc_pkg::CTL1_ENABLE] &&
                               !st_ff.ctl1[cmc_pkg::CTL1_LISTEN] && !st_ff.initReq &&
                               !sleepActive; // [RQ10]
        nxt_st.eng.ackErrAllowed = !st_ff.ctl1[cmc_pkg::CTL1_LISTEN]; // [RQ8]
        // Loopback changes nothing here: both events pass on in every mode.
        nxt_st.eng.txEvent = engIn.txDone; // [RQ7]
        nxt_st.eng.rxEvent = engIn.rxDone; // [RQ7]
        // Requesting initialization forces the pin recessive at once, mid-frame or not.
        nxt_st.txPin = (st_ff.ctl1[cmc_pkg::CTL1_LOOP] || st_ff.ctl1[cmc_pkg::CTL1_LISTEN] ||
                        st_ff.initReq || !st_ff.ctl1[cmc_pkg::CTL1_ENABLE] || sleepActive)
                       ? 1'b1 : engIn.txBit; // [RQ5] [RQ8] [RQ10]

        // Reset enters initialization with the pin recessive and the receive stages at
        // the idle bus level, so no false wake follows reset.
        if (srst) begin
            nxt_st = '0;
            nxt_st.initReq = cmc_pkg::INITREQ_RST;
            nxt_st.initAck = cmc_pkg::INITACK_RST;
            nxt_st.ctl1 = cmc_pkg::REG8_RST;
            nxt_st.txPin = 1'b1;
            nxt_st.rxSync1 = 1'b1;
            nxt_st.rxSync2 = 1'b1;
            nxt_st.rsp.awready = 1'b1;
            nxt_st.rsp.wready = 1'b1;
            nxt_st.rsp.arready = 1'b1;
            nxt_st.eng.ackErrAllowed = 1'b1;
        end
    end

    // The only clocked process of the block outside the wake filter.
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    // Every output is a field of the state register.
    assign axilRsp = st_ff.rsp;
    assign busTransmitPin = st_ff.txPin;
    assign engOut = st_ff.eng;

endmodule // cmc_mode_control

// [design/cmc_pkg.sv]
// Shared constants, register map and carrier types of the CAN mode-control block.
package cmc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_CTL0 = 6'h00;
    localparam logic [5:0] IDX_CTL1 = 6'h01;
    localparam logic [5:0] IDX_BTR0 = 6'h02;
    localparam logic [5:0] IDX_BTR1 = 6'h03;
    localparam logic [5:0] IDX_IDAC = 6'h04;
    localparam logic [5:0] IDX_ERRCNT = 6'h05;
    localparam logic [5:0] IDX_STATUS = 6'h06;
    localparam logic [5:0] IDX_ACC_BASE = 6'h08;
    localparam logic [5:0] IDX_ACC_LAST = 6'h17;
    localparam int ACC_COUNT = 16;

    // Field positions in can_control_one.
    localparam int CTL1_ENABLE = 7;
    localparam int CTL1_CLOCK_SOURCE_SELECT = 6;
    localparam int CTL1_LOOP = 5;
    localparam int CTL1_LISTEN = 4;
    localparam int CTL1_WAKEFLT = 2;
    localparam int CTL1_SLPACK = 1;
    localparam int CTL1_INITACK = 0;

    // Field positions in can_control_zero.
    localparam int CTL0_WAKEEN = 2;
    localparam int CTL0_SLPREQ = 1;
    localparam int CTL0_INITREQ = 0;

    // Reset values: the block leaves reset in initialization mode.
    localparam logic INITREQ_RST = 1'b1;
    localparam logic INITACK_RST = 1'b1;
    localparam logic [7:0] REG8_RST = 8'h00;

    // Bus resynchronization after leaving initialization.
    localparam logic [3:0] RESYNC_BITS = 4'hB;
    localparam logic [6:0] BUSOFF_SEQ_LAST = 7'h7F;

    // Wake-up filter time; a least time, so the cycle count rounds up.
    localparam int CLK_PERIOD_NS = 25;
    localparam int WAKE_FILTER_NS = 2000;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WAKE_CNT_LAST = 8'(WAKE_FILTER_CYC - 1);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } cmc_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cmc_axil_rsp_t;

    typedef struct packed {
        logic rxBusy;
        logic txPending;
        logic busOff;
        logic bitTick;
        logic txBit;
        logic errLoad;
        logic [7:0] tecIn;
        logic [7:0] recIn;
        logic txDone;
        logic rxDone;
    } cmc_engine_in_t;

    typedef struct packed {
        logic moduleEnable;
        logic clockSourceSelect;
        logic rxBit;
        logic ackIgnore;
        logic txAllowed;
        logic ackErrAllowed;
        logic busSynced;
        logic txEvent;
        logic rxEvent;
        logic [7:0] bitTiming0;
        logic [7:0] bitTiming1;
        logic [7:0] acceptCtl;
    } cmc_engine_out_t;

endpackage

// [design/cmc_wake_filter.sv]
// Wake-up detector for sleep mode, with optional low-pass filtering of dominant pulses.
module cmc_wake_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic armed,
    input wire logic filterOn,
    input wire logic rxLevel,
    // Result
    output logic wakePulse
);

    typedef struct packed {
        logic [7:0] cnt;
        logic pulse;
    } cmc_wake_state_t;

    cmc_wake_state_t st_ff;
    cmc_wake_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (srst || !armed || rxLevel) begin
            nxt_st.cnt = 8'h00;
        end else if (!filterOn) begin
            nxt_st.pulse = 1'b1; // [RQ11]
        end else if (st_ff.cnt == cmc_pkg::WAKE_CNT_LAST) begin
            nxt_st.pulse = 1'b1; // [RQ12]
            nxt_st.cnt = 8'h00;
        end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01; // [RQ12]
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign wakePulse = st_ff.pulse;

endmodule // cmc_wake_filter

// [testbench/cmc_can_node.sv]
// Behavioural model of the other nodes on the CAN bus, seen at the receive pin.
module cmc_can_node (
    // Clock
    input wire logic clk,
    // Bus
    output logic busLevel
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus is pulled recessive, so an idle bus reads 1.
    initial busLevel = 1'b1;

    // Holds the bus dominant for a number of clock cycles; called just after a rising edge.
    task automatic dominant(input int cycles);
        busLevel <= 1'b0;
        repeat (cycles) @(posedge clk);
        busLevel <= 1'b1;
    endtask
endmodule // cmc_can_node

// [testbench/cmc_mode_control_properties.sv]
// Port-level assertions of the CAN mode-control block.
module cmc_mode_control_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register bus
    input wire cmc_pkg::cmc_axil_req_t axilReq,
    input wire cmc_pkg::cmc_axil_rsp_t axilRsp,
    // Pins and engine
    input wire logic specialMode,
    input wire logic busReceivePin,
    input wire logic busTransmitPin,
    input wire cmc_pkg::cmc_engine_in_t engIn,
    input wire cmc_pkg::cmc_engine_out_t engOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_write_latency: assert property (axilReq.awvalid && axilRsp.awready
        && axilReq.wvalid && axilRsp.wready |-> ##1 !axilRsp.bvalid ##1 axilRsp.bvalid)
        else $error("write response not two cycles after the write was taken");
    a_read_latency: assert property (axilReq.arvalid && axilRsp.arready
        |=> axilRsp.rvalid && !axilRsp.arready)
        else $error("read data not one cycle after the address was taken");
    a_rdata_hold: assert property (axilRsp.rvalid && !axilReq.rready
        |=> axilRsp.rvalid && $stable(axilRsp.rdata))
        else $error("read data withdrawn before it was accepted");
    a_bresp_hold: assert property (axilRsp.bvalid && !axilReq.bready
        |=> axilRsp.bvalid && $stable(axilRsp.bresp))
        else $error("write response withdrawn before it was accepted");
    a_loop_tx_idle: assert property (engOut.ackIgnore && $past(engOut.ackIgnore)
        |-> busTransmitPin)
        else $error("transmit pin not recessive in loopback");
    a_loop_rx_path: assert property (engOut.ackIgnore && $past(engOut.ackIgnore)
        |-> engOut.rxBit == $past(engIn.txBit))
        else $error("receiver not fed from the transmitter in loopback");
    a_listen_silent: assert property (
        !engOut.ackErrAllowed && !$past(engOut.ackErrAllowed)
        |-> !engOut.txAllowed && busTransmitPin)
        else $error("bus driven or transmission allowed in listen-only mode");
    a_event_delay: assert property (engOut.txEvent == $past(engIn.txDone)
        && engOut.rxEvent == $past(engIn.rxDone))
        else $error("transmit or receive event not one cycle after completion");
endmodule // cmc_mode_control_properties

bind cmc_mode_control cmc_mode_control_properties u_props (.clk(clk), .srst(srst),
    .axilReq(axilReq), .axilRsp(axilRsp), .specialMode(specialMode),
    .busReceivePin(busReceivePin), .busTransmitPin(busTransmitPin), .engIn(engIn),
    .engOut(engOut));

// [testbench/test_can_mode_control_reg1.sv]
// Self-checking bench for the CAN mode-control registers and their handshakes.
module test_can_mode_control_reg1;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] aCtl0 = {cmc_pkg::IDX_CTL0, 2'b00};
    localparam logic [7:0] aCtl1 = {cmc_pkg::IDX_CTL1, 2'b00};
    localparam logic [7:0] aBtr0 = {cmc_pkg::IDX_BTR0, 2'b00};
    localparam logic [7:0] aErr = {cmc_pkg::IDX_ERRCNT, 2'b00};
    logic clk;
    logic srst;
    logic specialMode;
    logic busLevel;
    logic busTransmitPin;
    cmc_pkg::cmc_axil_req_t req;
    cmc_pkg::cmc_axil_rsp_t rsp;
    cmc_pkg::cmc_engine_in_t eng;
    cmc_pkg::cmc_engine_out_t engOut;
    int miscompares;
    int checked;
    string tname;

    cmc_mode_control dut (.clk(clk), .srst(srst), .axilReq(req), .axilRsp(rsp),
        .specialMode(specialMode), .busReceivePin(busLevel), .busTransmitPin(busTransmitPin),
        .engIn(eng), .engOut(engOut));
    cmc_can_node node (.clk(clk), .busLevel(busLevel));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h, expected %h", $time, tname, got, exp);
        end
    endtask

    // Ready rises with the request, or after lag answer cycles, and is left high afterwards.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int lag = 0);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.bready <= (lag == 0);
        forever begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) break;
            if (rsp.bvalid) lag--;
            if (rsp.bvalid && lag <= 0) req.bready <= 1'b1;
        end
        chk({30'h0, rsp.bresp}, {30'h0, cmc_pkg::RESP_OKAY});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input logic [1:0] er = cmc_pkg::RESP_OKAY, input int lag = 0);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= (lag == 0);
        forever begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) break;
            if (rsp.rvalid) lag--;
            if (rsp.rvalid && lag <= 0) req.rready <= 1'b1;
        end
        chk({30'h0, rsp.rresp}, {30'h0, er});
        chk(rsp.rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulseTick();
        eng.bitTick <= 1'b1;
        @(posedge clk);
        eng.bitTick <= 1'b0;
        tick(3);
    endtask

    task automatic loadErr();
        eng.errLoad <= 1'b1;
        @(posedge clk);
        eng.errLoad <= 1'b0;
        tick(2);
    endtask

    task automatic done();
        $display("test %s ended, %0d mismatches so far", tname, miscompares);
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        miscompares = 0;
        checked = 0;
        srst = 1'b1;
        specialMode = 1'b0;
        req = '0;
        req.wstrb = 4'hF;
        eng = '0;
        eng.tecIn = 8'h33;
        eng.recIn = 8'h44;
        tick(20);
        srst <= 1'b0;
        tname = "reset";
        rdc(aCtl1, 32'h01);
        rdc(aCtl0, 32'h01);
        rdc(8'h1C, 32'h0, cmc_pkg::RESP_SLVERR);
        done();
        tname = "enable";
        wr(aCtl1, 8'hFC);
        rdc(aCtl1, 32'hF5);
        chk({30'h0, engOut.moduleEnable, engOut.clockSourceSelect}, 32'h3);
        wr(aCtl1, 8'h00);
        rdc(aCtl1, 32'h81);
        chk({31'h0, engOut.clockSourceSelect}, 32'h0);
        specialMode <= 1'b1;
        wr(aCtl1, 8'h00);
        rdc(aCtl1, 32'h01);
        chk({31'h0, engOut.moduleEnable}, 32'h0);
        wr(aCtl1, 8'hA0);
        specialMode <= 1'b0;
        wr(aBtr0, 8'h5A, 3);
        rdc(aBtr0, 32'h5A, cmc_pkg::RESP_OKAY, 3);
        done();
        tname = "loopback";
        wr(aCtl0, 8'h00);
        tick(2);
        rdc(aCtl1, 32'hA0);
        chk({31'h0, busTransmitPin}, 32'h1);
        wr(aCtl1, 8'h00);
        wr(aBtr0, 8'h00);
        rdc(aCtl1, 32'hA0);
        rdc(aBtr0, 32'h5A);
        eng.txBit <= 1'b1;
        tick(2);
        repeat (10) pulseTick();
        chk({31'h0, engOut.busSynced}, 32'h0);
        pulseTick();
        chk({31'h0, engOut.busSynced}, 32'h1);
        eng.txDone <= 1'b1;
        eng.rxDone <= 1'b1;
        @(posedge clk);
        eng.txDone <= 1'b0;
        eng.rxDone <= 1'b0;
        @(posedge clk);
        chk({30'h0, engOut.txEvent, engOut.rxEvent}, 32'h3);
        done();
        tname = "listen";
        wr(aCtl0, 8'h01);
        tick(2);
        wr(aCtl1, 8'h90);
        loadErr();
        rdc(aErr, 32'h0000);
        wr(aCtl0, 8'h00);
        eng.txBit <= 1'b0;
        tick(3);
        chk({30'h0, busTransmitPin, engOut.txAllowed}, 32'h2);
        wr(aCtl0, 8'h01);
        tick(2);
        wr(aCtl1, 8'h80);
        loadErr();
        rdc(aErr, 32'h4433);
        done();
        tname = "sleep";
        wr(aCtl0, 8'h04);
        tick(3);
        chk({31'h0, busTransmitPin}, 32'h0);
        eng.txBit <= 1'b1;
        eng.rxBusy <= 1'b1;
        wr(aCtl0, 8'h06);
        tick(3);
        rdc(aCtl1, 32'h80);
        eng.rxBusy <= 1'b0;
        tick(3);
        rdc(aCtl1, 32'h82);
        node.dominant(3);
        tick(6);
        rdc(aCtl1, 32'h80);
        rdc(aCtl0, 32'h04);
        done();
        tname = "filter";
        wr(aCtl0, 8'h05);
        tick(2);
        wr(aCtl1, 8'h84);
        wr(aCtl0, 8'h04);
        wr(aCtl0, 8'h06);
        tick(3);
        rdc(aCtl1, 32'h86);
        // A pulse of half the filter time must not wake; one well past it must.
        node.dominant(cmc_pkg::WAKE_FILTER_CYC / 2);
        tick(6);
        rdc(aCtl1, 32'h86);
        node.dominant(cmc_pkg::WAKE_FILTER_CYC + 20);
        tick(6);
        rdc(aCtl1, 32'h84);
        done();
        end_sim();
    end
endmodule // test_can_mode_control_reg1
